/* File: test/dsau_chk.sv */
// Checker on the ports of the data space access unit top.
// Assumes one clock domain; bound to every top instance.
module dsau_chk import dsau_pkg::*; (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic OP_VALID,
  input wire logic [2:0] OP_KIND,
  input wire logic [1:0] OP_MODE,
  input wire logic OP_BYTE,
  input wire logic [15:0] OP_ADDR,
  input wire logic OP_DUAL,
  input wire logic [15:0] X_RDATA,
  input wire logic X_VALID,
  input wire logic Y_VALID,
  input wire logic [15:0] OP_EA,
  input wire logic ADDR_TRAP
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Accepted operations
  // ****************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  logic acc, rd, rw, d16, special_function_register;
  // Ops seen in the trap cycle are dropped, so they never count
  assign acc = OP_VALID && !ADDR_TRAP;
  assign rd = acc && OP_KIND == KD_READ;
  assign rw = rd || (acc && OP_KIND == KD_WRITE);
  assign d16 = OP_MODE == AM_DIRECT16;
  assign special_function_register = OP_ADDR >= 16'h0100 && OP_ADDR <= SFR_LAST;
  sequence s_odd_word;
    rw && d16 && !OP_BYTE && OP_ADDR[0];
  endsequence
  sequence s_trap_pulse;
    ADDR_TRAP ##1 !ADDR_TRAP;
  endsequence
  // ****************************************
  // Properties
  // ****************************************
  a_odd_traps: assert property (s_odd_word |=> s_trap_pulse)
    else $error("odd word access without one trap pulse");
  a_even_quiet: assert property (rw && d16 && !(OP_ADDR[0] && !OP_BYTE) |=> !ADDR_TRAP)
    else $error("trap on aligned access");
  a_read_done: assert property (rd |=> X_VALID)
    else $error("read did not complete");
  a_xv_cause: assert property (X_VALID |-> $past(rd))
    else $error("x data valid without a read");
  a_y_dual: assert property (Y_VALID |-> $past(rd) && $past(OP_DUAL))
    else $error("y data valid without dual read");
  a_ea_full: assert property (rw && d16 |=> OP_EA == $past(OP_ADDR))
    else $error("direct address not passed whole");
  a_ea_near: assert property (rw && OP_MODE == AM_DIRECT13 |=> OP_EA == ($past(OP_ADDR) & 16'h1FFF))
    else $error("near address not masked");
  a_upper_zero: assert property (rd && d16 && OP_ADDR[15] |=> X_RDATA == 16'h0000)
    else $error("upper half read not zero");
  a_sfr_zero: assert property (rd && d16 && special_function_register |=> X_RDATA == 16'h0000)
    else $error("unused register space not zero");
  a_byte_lane: assert property (rd && OP_BYTE |=> X_RDATA[15:8] == 8'h00)
    else $error("byte read upper lane not zero");
endmodule

bind dsau_top dsau_chk dsau_chk_inst (.REF_CLK(REF_CLK), .RST(RST), .OP_VALID(OP_VALID),
  .OP_KIND(OP_KIND), .OP_MODE(OP_MODE), .OP_BYTE(OP_BYTE), .OP_ADDR(OP_ADDR),
  .OP_DUAL(OP_DUAL), .X_RDATA(X_RDATA), .X_VALID(X_VALID), .Y_VALID(Y_VALID),
  .OP_EA(OP_EA), .ADDR_TRAP(ADDR_TRAP));

/* File: test/dsau_pipe_model.sv */
// Execution pipeline model issuing one operation at a time.
// Assumes the bench calls op from a single process.
module dsau_pipe_model import dsau_pkg::*; (
  input wire logic clk,
  output logic op_valid,
  output logic [2:0] op_kind,
  output logic [1:0] op_mode,
  output logic op_byte,
  output logic [3:0] op_ptr,
  output logic [15:0] op_addr,
  output logic [15:0] op_wdata,
  output logic op_load,
  output logic [3:0] op_dst,
  output logic op_dual,
  output logic [3:0] op_yptr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    {op_valid, op_kind, op_mode, op_byte, op_ptr, op_load, op_dst, op_dual, op_yptr} = '0;
    op_addr = 16'h5A5A;
    op_wdata = 16'hA5A5;
  end
  // One idle edge between ops keeps clear of the trap cycle
  task automatic op(input dsau_kind_t k, dsau_mode_t m, logic b, logic [3:0] p,
                    logic [15:0] a, w, logic ld, logic [3:0] d, logic du, logic [3:0] y);
    @(posedge clk);
    op_valid <= 1'b1;
    {op_kind, op_mode, op_byte, op_ptr, op_addr} <= {k, m, b, p, a};
    {op_wdata, op_load, op_dst, op_dual, op_yptr} <= {w, ld, d, du, y};
    @(posedge clk);
    op_valid <= 1'b0;
    op_addr <= ~a;
    op_wdata <= ~w;
  endtask
endmodule

/* File: test/tb_top.sv */
// Self-checking bench for the data space access unit.
// Assumes the pipeline model and the bound checker beside it.
module tb_top import dsau_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, reg_wr, reg_rd, op_valid, op_byte, op_load, op_dual, x_valid, y_valid;
  logic addr_trap;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, op_addr, op_wdata, x_rdata, y_rdata, op_ea;
  logic [15:0] v, w, r, a;
  logic [15:0] mem [0:1023];
  logic [15:0] q [$];
  logic [2:0] op_kind;
  logic [1:0] op_mode;
  logic [3:0] op_ptr, op_dst, op_yptr;
  int miscompares, total_checks, cycles;
  dsau_top dsau_top_inst (.REF_CLK(clk), .RST(rst), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .OP_VALID(op_valid), .OP_KIND(op_kind), .OP_MODE(op_mode), .OP_BYTE(op_byte),
    .OP_PTR(op_ptr), .OP_ADDR(op_addr), .OP_WDATA(op_wdata), .OP_LOAD(op_load),
    .OP_DST(op_dst), .OP_DUAL(op_dual), .OP_YPTR(op_yptr), .X_RDATA(x_rdata),
    .X_VALID(x_valid), .Y_RDATA(y_rdata), .Y_VALID(y_valid), .OP_EA(op_ea),
    .ADDR_TRAP(addr_trap));
  dsau_pipe_model dsau_pipe_model_inst (.clk(clk), .op_valid(op_valid), .op_kind(op_kind),
    .op_mode(op_mode), .op_byte(op_byte), .op_ptr(op_ptr), .op_addr(op_addr),
    .op_wdata(op_wdata), .op_load(op_load), .op_dst(op_dst), .op_dual(op_dual),
    .op_yptr(op_yptr));
  // ****************************************
  // Tasks and expectations
  // ****************************************
  function automatic logic [15:0] sext(input logic [15:0] s);
    return {{8{s[7]}}, s[7:0]};
  endfunction
  task automatic chk(input string n, input logic [15:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rw_reg(input logic [15:0] ad, d);
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, ad, d};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [15:0] ad, output logic [15:0] d);
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'b1, ad};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic xop(input dsau_kind_t k, dsau_mode_t m, logic b, logic [15:0] ad, d);
    dsau_pipe_model_inst.op(k, m, b, 4'h0, ad, d, 1'b0, 4'h0, 1'b0, 4'h0);
    #1;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Whole run needs about 350 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      end_of_test();
    end
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    rst = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    v = 16'($urandom(58));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < NUM_WREG; i++)
    begin
      rd_reg(WREG_OFS[i], v);
      chk("wreg reset", WREG_RESET, v);
      w = 16'($urandom);
      rw_reg(WREG_OFS[i], w);
      rd_reg(WREG_OFS[i], v);
      chk("wreg rw", w, v);
    end
    rd_reg(OFS_MOD_START, v);
    chk("mod start", MOD_START_RESET, v);
    rd_reg(OFS_MOD_END, v);
    chk("mod end", MOD_END_RESET, v);
    rd_reg(16'h0100, v);
    chk("unmapped", 16'h0000, v);
    for (int i = 0; i < 40; i++)
    begin
      a = RAM_BASE + 16'(($urandom % 1024) * 2);
      w = 16'($urandom);
      xop(KD_WRITE, AM_DIRECT16, 1'b0, a, w);
      chk("aligned trap", 16'h0000, {15'h0, addr_trap});
      q.push_back(a);
      mem[(a - RAM_BASE) >> 1] = w;
    end
    foreach (q[i])
    begin
      xop(KD_READ, AM_DIRECT16, 1'b0, q[i], 16'h0000);
      chk("ram word", mem[(q[i] - RAM_BASE) >> 1], x_rdata);
    end
    // Near write with junk in the top bits, read back in full
    w = 16'($urandom);
    xop(KD_WRITE, AM_DIRECT13, 1'b0, 16'hE900, w);
    xop(KD_READ, AM_DIRECT16, 1'b0, 16'h0900, 16'h0000);
    chk("near write", w, x_rdata);
    xop(KD_WRITE, AM_DIRECT16, 1'b1, 16'h0901, 16'h12AB);
    xop(KD_READ, AM_DIRECT16, 1'b0, 16'h0900, 16'h0000);
    chk("byte lane", {8'hAB, w[7:0]}, x_rdata);
    xop(KD_READ, AM_DIRECT16, 1'b1, 16'h0901, 16'h0000);
    chk("byte hi", 16'h00AB, x_rdata);
    xop(KD_READ, AM_DIRECT16, 1'b1, 16'h0900, 16'h0000);
    chk("byte lo", {8'h00, w[7:0]}, x_rdata);
    xop(KD_WRITE, AM_DIRECT16, 1'b0, 16'h0901, ~w);
    chk("odd write trap", 16'h0001, {15'h0, addr_trap});
    xop(KD_READ, AM_DIRECT16, 1'b0, 16'h0900, 16'h0000);
    chk("write dropped", {8'hAB, w[7:0]}, x_rdata);
    // Byte then misaligned word through a stepped pointer
    rw_reg(WREG_OFS[1], 16'h0900);
    dsau_pipe_model_inst.op(KD_READ, AM_POSTINC, 1'b1, 4'h1, 0, 0, 0, 4'h0, 0, 4'h0);
    dsau_pipe_model_inst.op(KD_READ, AM_POSTINC, 1'b0, 4'h1, 0, 0, 0, 4'h0, 0, 4'h0);
    #1;
    chk("odd read trap", 16'h0001, {15'h0, addr_trap});
    chk("odd read done", 16'h0001, {15'h0, x_valid});
    rd_reg(WREG_OFS[1], v);
    chk("post inc", 16'h0903, v);
    // Both faults are latched; the last one leaves its address
    rd_reg(OFS_STATUS, v);
    chk("trap status", 16'h0003, v);
    rd_reg(OFS_FAULT_EA, v);
    chk("fault address", 16'h0901, v);
    rw_reg(OFS_STATUS, 16'h0003);
    rd_reg(OFS_STATUS, v);
    chk("status clear", 16'h0000, v);
    r = 16'($urandom);
    rw_reg(WREG_OFS[2], r);
    dsau_pipe_model_inst.op(KD_READ, AM_DIRECT16, 1'b1, 4'h0, 16'h0901, 0, 1, 4'h2, 0, 4'h0);
    rd_reg(WREG_OFS[2], v);
    chk("byte load", {r[15:8], 8'hAB}, v);
    xop(KD_READ, AM_DIRECT16, 1'b0, WREG_OFS[2], 16'h0000);
    chk("sfr read", {r[15:8], 8'hAB}, x_rdata);
    for (int i = 0; i < 2; i++)
    begin
      r = 16'($urandom);
      r[7] = i[0];
      rw_reg(WREG_OFS[3], r);
      dsau_pipe_model_inst.op(KD_SIGNX, AM_INDIRECT, 1'b0, 4'h3, 0, 0, 0, 4'h5, 0, 4'h0);
      dsau_pipe_model_inst.op(KD_ZEROX, AM_INDIRECT, 1'b0, 4'h3, 0, 0, 0, 4'h6, 0, 4'h0);
      rd_reg(WREG_OFS[5], v);
      chk("sign ext", sext(r), v);
      rd_reg(WREG_OFS[6], v);
      chk("zero ext", {8'h00, r[7:0]}, v);
    end
    // Dual read: X through one pointer, Y region through another
    w = 16'($urandom);
    r = 16'($urandom);
    xop(KD_WRITE, AM_DIRECT16, 1'b0, 16'h0A00, w);
    xop(KD_WRITE, AM_DIRECT16, 1'b0, Y_BASE, r);
    rw_reg(WREG_OFS[7], 16'h0A00);
    rw_reg(WREG_OFS[8], Y_BASE);
    dsau_pipe_model_inst.op(KD_READ, AM_INDIRECT, 1'b0, 4'h7, 0, 0, 0, 4'h0, 1, 4'h8);
    #1;
    chk("x operand", w, x_rdata);
    chk("y operand", r, y_rdata);
    chk("y valid", 16'h0001, {15'h0, y_valid});
    rd_reg(WREG_OFS[8], v);
    chk("y step", Y_BASE + WORD_STEP, v);
    // Word step past the buffer end wraps the X pointer to its start
    rw_reg(OFS_MOD_CTRL, 16'h0001);
    rw_reg(OFS_MOD_START, 16'h0900);
    rw_reg(OFS_MOD_END, 16'h0903);
    rw_reg(WREG_OFS[9], 16'h0902);
    dsau_pipe_model_inst.op(KD_READ, AM_POSTINC, 1'b0, 4'h9, 0, 0, 0, 4'h0, 0, 4'h0);
    rd_reg(WREG_OFS[9], v);
    chk("modulo wrap", 16'h0900, v);
    for (int i = 0; i < 5; i++)
    begin
      a = (i == 0) ? 16'h0100 : (i == 1) ? 16'h07FE : (i == 2) ? 16'h2000 : 16'h8000 + 16'(i);
      xop(KD_READ, AM_DIRECT16, i[0], a, 16'h0000);
      chk("empty read", 16'h0000, x_rdata);
    end
    end_of_test();
  end
endmodule

/* File: verilog/dsau_agu.sv */
// One address generator: effective address and updated pointer.
// Assumes pointer and configuration come from registers of the caller.
module dsau_agu import dsau_pkg::*; #(
  parameter bit BREV_OK = 1'b1
) (
  input wire logic [15:0] ptr,
  input wire logic [15:0] dir_addr,
  input wire logic [1:0] mode,
  input wire logic byte_op,
  input wire logic mod_en,
  input wire logic [15:0] mod_start,
  input wire logic [15:0] mod_end,
  input wire logic brev_en,
  input wire logic [15:0] brev_step,
  output logic [15:0] ea,
  output logic [15:0] next_ptr
);

  logic [15:0] step;
  logic [15:0] inc;
  logic [14:0] rsum;

  function automatic logic [14:0] rev15(input logic [14:0] v);
    logic [14:0] r;
    for (int i = 0; i < 15; i++)
    begin
      r[i] = v[14-i];
    end
    return r;
  endfunction

  always_comb
  begin
    step = byte_op ? BYTE_STEP : WORD_STEP;
    inc = ptr + step;
    rsum = rev15(ptr[15:1]) + rev15(brev_step[15:1]);
    unique case (dsau_mode_t'(mode))
      AM_DIRECT13: ea = {3'h0, dir_addr[12:0]};
      AM_DIRECT16: ea = dir_addr;
      default: ea = ptr;
    endcase
    next_ptr = inc;
    // Reverse carry walks a buffer in bit-reversed word order
    if (BREV_OK && brev_en)
    begin
      next_ptr = {rev15(rsum), ptr[0]};
    end
    else if (mod_en && (ptr <= mod_end) && (inc > mod_end))
    begin
      next_ptr = mod_start;
    end
  end

endmodule

/* File: verilog/dsau_pkg.sv */
// Constants and types shared by the data space access unit.
// Assumes a 16-bit byte-addressed data space on one core clock.
package dsau_pkg;

  // ****************************************
  // Data space layout
  // ****************************************
  localparam int NUM_WREG = 11;
  localparam logic [15:0] SFR_LAST = 16'h07FF;
  localparam logic [15:0] NEAR_LAST = 16'h1FFF;
  localparam logic [15:0] RAM_BASE = 16'h0800;
  localparam int RAM_BYTES = 2048;
  localparam logic [15:0] Y_BASE = 16'h0C00;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] WREG_RESET = 16'h0000;
  localparam logic [NUM_WREG-1:0][15:0] WREG_OFS = {
    16'h0014, 16'h0012, 16'h0010, 16'h000E, 16'h000C, 16'h000A,
    16'h8000, 16'h0006, 16'h0004, 16'h0002, 16'h0000};

  // ****************************************
  // Control registers of the unit
  // ****************************************
  localparam logic [15:0] OFS_MOD_CTRL = 16'h0050;
  localparam logic [15:0] OFS_MOD_START = 16'h0052;
  localparam logic [15:0] OFS_MOD_END = 16'h0054;
  localparam logic [15:0] OFS_BREV_STEP = 16'h0056;
  localparam logic [15:0] OFS_STATUS = 16'h0058;
  localparam logic [15:0] OFS_FAULT_EA = 16'h005A;
  localparam int MC_XMOD = 0;
  localparam int MC_YMOD = 1;
  localparam int MC_BREV = 2;
  localparam int ST_MIS_RD = 0;
  localparam int ST_MIS_WR = 1;
  localparam logic [2:0] MOD_CTRL_RESET = 3'h0;
  localparam logic [15:0] MOD_START_RESET = 16'h0800;
  localparam logic [15:0] MOD_END_RESET = 16'h0FFF;
  localparam logic [15:0] BREV_RESET = 16'h0000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {KD_NONE = 3'h0, KD_READ = 3'h1, KD_WRITE = 3'h2,
                            KD_SIGNX = 3'h3, KD_ZEROX = 3'h4} dsau_kind_t;
  typedef enum logic [1:0] {AM_INDIRECT = 2'h0, AM_POSTINC = 2'h1,
                            AM_DIRECT13 = 2'h2, AM_DIRECT16 = 2'h3} dsau_mode_t;
  typedef enum logic {FS_RUN = 1'b0, FS_TRAP = 1'b1} dsau_fsm_t;

endpackage

/* File: verilog/dsau_ram.sv */
// Data RAM as two byte lanes with one word decode and two read ports.
// Assumes writes and addresses arrive on the core clock.
module dsau_ram import dsau_pkg::*; #(
  parameter logic [15:0] BASE = RAM_BASE,
  parameter int BYTES = RAM_BYTES
) (
  input wire logic clk,
  input wire logic we_lo,
  input wire logic we_hi,
  input wire logic [15:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] xaddr,
  output logic [15:0] xdata,
  output logic xhit,
  input wire logic [15:0] yaddr,
  output logic [15:0] ydata,
  output logic yhit
);

  localparam int WORDS = BYTES / 2;
  localparam int AW = $clog2(WORDS);

  if (BYTES < 4 || (BYTES % 2) != 0 || int'(BASE) + BYTES > 32768)
  begin : g_bad_size
    $error("dsau_ram: size or base out of range");
  end

  logic [7:0] lane_lo [WORDS];
  logic [7:0] lane_hi [WORDS];
  logic [15:0] woff;
  logic [15:0] xoff;
  logic [15:0] yoff;
  logic whit;

  always_comb
  begin
    woff = waddr - BASE;
    xoff = xaddr - BASE;
    yoff = yaddr - BASE;
    whit = (waddr >= BASE) && (int'(waddr) < int'(BASE) + BYTES);
    xhit = (xaddr >= BASE) && (int'(xaddr) < int'(BASE) + BYTES);
    yhit = (yaddr >= BASE) && (int'(yaddr) < int'(BASE) + BYTES);
    xdata = xhit ? {lane_hi[xoff[AW:1]], lane_lo[xoff[AW:1]]} : 16'h0000;
    ydata = yhit ? {lane_hi[yoff[AW:1]], lane_lo[yoff[AW:1]]} : 16'h0000;
  end

  // Separate lane strobes, shared word index
  always_ff @(posedge clk)
  begin
    if (we_lo && whit)
    begin
      lane_lo[woff[AW:1]] <= wdata[7:0];
    end
    if (we_hi && whit)
    begin
      lane_hi[woff[AW:1]] <= wdata[15:8];
    end
  end

endmodule

/* File: verilog/dsau_top.sv */
// Data space access unit: address generation, byte lanes, alignment trap.
// Assumes the execution pipeline drives one operation per cycle on REF_CLK.
//
// Added by the designer: the strobed register port.

// Notes on behaviour
// - Post-increment steps a pointer by one for bytes, two for words.
// - Byte read fetches the word, picks a byte by address bit zero.
// - One word decode, separate low and high write strobes per lane.
// - A word access at an odd X address raises the address error trap.
// - A misaligned read still completes; the trap follows it.
// - A misaligned write updates pointers but suppresses the memory write.
// - A byte load into a working register changes only its low byte.
// - Sign extend and zero extend a working register's low byte.
// - Addresses 0x0000 to 0x07FF decode as special function registers.
// - Unimplemented special function register addresses read as zero.
// - Direct thirteen-bit addressing reaches 0x0000 to 0x1FFF.
// - Sixteen-bit direct or register indirect addressing reaches all data space.
// - Two independent address generators with separate read paths.
// - X path has separate read and write buses; it serves unified reads.
// - Y path supplies the second operand only for dual-operand operations.
// - Modulo addressing on X and Y; bit reversal only on X writes.
// - All writes use the unified range; X/Y boundary is fixed.
// - Effective addresses are 16-bit, byte granular, 64 KB range.
// - Reads outside implemented memory return zero.
// - Addresses with the top bit set never reach data RAM.
module dsau_top import dsau_pkg::*; #(
  parameter logic [15:0] RAM_START = RAM_BASE,
  parameter int RAM_SIZE = RAM_BYTES,
  parameter logic [15:0] Y_START = Y_BASE
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [15:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  input wire logic OP_VALID,
  input wire logic [2:0] OP_KIND,
  input wire logic [1:0] OP_MODE,
  input wire logic OP_BYTE,
  input wire logic [3:0] OP_PTR,
  input wire logic [15:0] OP_ADDR,
  input wire logic [15:0] OP_WDATA,
  input wire logic OP_LOAD,
  input wire logic [3:0] OP_DST,
  input wire logic OP_DUAL,
  input wire logic [3:0] OP_YPTR,
  output logic [15:0] X_RDATA,
  output logic X_VALID,
  output logic [15:0] Y_RDATA,
  output logic Y_VALID,
  output logic [15:0] OP_EA,
  output logic ADDR_TRAP
);

  if (int'(Y_START) <= int'(RAM_START) || int'(Y_START) >= int'(RAM_START) + RAM_SIZE)
  begin : g_bad_split
    $error("dsau_top: Y boundary outside data RAM");
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    dsau_fsm_t fsm;
    logic [NUM_WREG-1:0][15:0] w;
    logic [15:0] x_rdata;
    logic [15:0] y_rdata;
    logic [15:0] reg_rdata;
    logic [15:0] ea_out;
    logic [15:0] fault_ea;
    logic [15:0] mod_start;
    logic [15:0] mod_end;
    logic [15:0] brev_step;
    logic [2:0] mod_ctrl;
    logic [1:0] status;
    logic x_valid;
    logic y_valid;
    logic trap;
  } dsau_state_t;

  dsau_state_t st;
  dsau_state_t next_st;

  dsau_kind_t kind;
  logic take;
  logic is_rd;
  logic is_wr;
  logic misaligned;
  logic mem_we_lo;
  logic mem_we_hi;
  logic [15:0] wr_data;
  logic [15:0] x_ptr;
  logic [15:0] y_ptr;
  logic [15:0] x_ea;
  logic [15:0] y_ea;
  logic [15:0] x_next;
  logic [15:0] y_next;
  logic [15:0] x_ram;
  logic [15:0] y_ram;
  logic x_hit;
  logic y_hit;
  logic [15:0] x_word;
  logic [15:0] x_val;
  logic [15:0] y_word;
  logic [15:0] sfr_word;
  logic [15:0] reg_word;
  logic [15:0] src;
  logic [1:0] st_set;
  logic [1:0] st_clr;
  logic brev_wr;
  int x_sfr_idx;
  int reg_idx;

  // ****************************************
  // Decode helpers
  // ****************************************
  // Miss is NUM_WREG; the shared word decode ignores address bit zero
  function automatic int wreg_find(input logic [15:0] a);
    int idx;
    idx = NUM_WREG;
    for (int i = 0; i < NUM_WREG; i++)
    begin
      if (WREG_OFS[i] == {a[15:1], 1'b0})
      begin
        idx = i;
      end
    end
    return idx;
  endfunction

  function automatic logic [15:0] wreg_get(input logic [NUM_WREG-1:0][15:0] w,
                                           input logic [3:0] sel);
    logic [15:0] v;
    v = 16'h0000;
    if (int'(sel) < NUM_WREG)
    begin
      v = w[sel];
    end
    return v;
  endfunction

  // ****************************************
  // Address generators and RAM
  // ****************************************
  assign x_ptr = wreg_get(st.w, OP_PTR);
  assign y_ptr = wreg_get(st.w, OP_YPTR);
  assign brev_wr = st.mod_ctrl[MC_BREV] && (kind == KD_WRITE);

  dsau_agu #(
    .BREV_OK(1'b1)
  ) u_xagu (
    .ptr(x_ptr),
    .dir_addr(OP_ADDR),
    .mode(OP_MODE),
    .byte_op(OP_BYTE),
    .mod_en(st.mod_ctrl[MC_XMOD]),
    .mod_start(st.mod_start),
    .mod_end(st.mod_end),
    .brev_en(brev_wr),
    .brev_step(st.brev_step),
    .ea(x_ea),
    .next_ptr(x_next)
  );

  // Y never bit-reverses: that mode exists only for X writes
  dsau_agu #(
    .BREV_OK(1'b0)
  ) u_yagu (
    .ptr(y_ptr),
    .dir_addr(16'h0000),
    .mode(AM_POSTINC),
    .byte_op(1'b0),
    .mod_en(st.mod_ctrl[MC_YMOD]),
    .mod_start(st.mod_start),
    .mod_end(st.mod_end),
    .brev_en(1'b0),
    .brev_step(16'h0000),
    .ea(y_ea),
    .next_ptr(y_next)
  );

  dsau_ram #(
    .BASE(RAM_START),
    .BYTES(RAM_SIZE)
  ) u_ram (
    .clk(REF_CLK),
    .we_lo(mem_we_lo),
    .we_hi(mem_we_hi),
    .waddr(x_ea),
    .wdata(wr_data),
    .xaddr(x_ea),
    .xdata(x_ram),
    .xhit(x_hit),
    .yaddr(y_ea),
    .ydata(y_ram),
    .yhit(y_hit)
  );

  // ****************************************
  // Read data paths
  // ****************************************
  always_comb
  begin
    x_sfr_idx = x_ea[15] ? NUM_WREG : wreg_find(x_ea);
    sfr_word = 16'h0000;
    if (x_sfr_idx < NUM_WREG)
    begin
      sfr_word = st.w[x_sfr_idx];
    end
    if (x_ea[15])
    begin
      x_word = 16'h0000;
    end
    else if (x_ea <= SFR_LAST)
    begin
      x_word = sfr_word;
    end
    else
    begin
      x_word = x_hit ? x_ram : 16'h0000;
    end
    x_val = x_word;
    if (OP_BYTE)
    begin
      x_val = {8'h00, x_ea[0] ? x_word[15:8] : x_word[7:0]};
    end
    // Y reads beyond its half of RAM give zero, like unmapped space
    y_word = (y_hit && (y_ea >= Y_START)) ? y_ram : 16'h0000;
    wr_data = OP_BYTE ? {OP_WDATA[7:0], OP_WDATA[7:0]} : OP_WDATA;
  end

  // ****************************************
  // Operation control
  // ****************************************
  always_comb
  begin
    kind = dsau_kind_t'(OP_KIND);
    take = OP_VALID && (st.fsm == FS_RUN);
    is_rd = take && (kind == KD_READ);
    is_wr = take && (kind == KD_WRITE);
    misaligned = (is_rd || is_wr) && !OP_BYTE && x_ea[0];
    mem_we_lo = is_wr && !misaligned && (!OP_BYTE || !x_ea[0]);
    mem_we_hi = is_wr && !misaligned && (!OP_BYTE || x_ea[0]);
    src = x_ptr;
    st_set = {misaligned && is_wr, misaligned && is_rd};
    st_clr = (REG_WR && (REG_ADDR == OFS_STATUS)) ? REG_WDATA[1:0] : 2'h0;
  end

  // ****************************************
  // Register port decode
  // ****************************************
  always_comb
  begin
    reg_idx = wreg_find(REG_ADDR);
    reg_word = 16'h0000;
    if (reg_idx < NUM_WREG)
    begin
      reg_word = st.w[reg_idx];
    end
    else if (REG_ADDR == OFS_MOD_CTRL)
    begin
      reg_word = {13'h0000, st.mod_ctrl};
    end
    else if (REG_ADDR == OFS_MOD_START)
    begin
      reg_word = st.mod_start;
    end
    else if (REG_ADDR == OFS_MOD_END)
    begin
      reg_word = st.mod_end;
    end
    else if (REG_ADDR == OFS_BREV_STEP)
    begin
      reg_word = st.brev_step;
    end
    else if (REG_ADDR == OFS_STATUS)
    begin
      reg_word = {14'h0000, st.status};
    end
    else if (REG_ADDR == OFS_FAULT_EA)
    begin
      reg_word = st.fault_ea;
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    next_st = st;
    next_st.x_valid = 1'b0;
    next_st.y_valid = 1'b0;
    next_st.trap = 1'b0;
    next_st.fsm = FS_RUN;
    next_st.reg_rdata = REG_RD ? reg_word : 16'h0000;
    if (take)
    begin
      next_st.ea_out = x_ea;
    end
    // Pointer moves even when the memory write is dropped
    if ((is_rd || is_wr) && (dsau_mode_t'(OP_MODE) == AM_POSTINC) &&
        (int'(OP_PTR) < NUM_WREG))
    begin
      next_st.w[OP_PTR] = x_next;
    end
    if (mem_we_lo && (x_sfr_idx < NUM_WREG))
    begin
      next_st.w[x_sfr_idx][7:0] = wr_data[7:0];
    end
    if (mem_we_hi && (x_sfr_idx < NUM_WREG))
    begin
      next_st.w[x_sfr_idx][15:8] = wr_data[15:8];
    end
    if (is_rd)
    begin
      next_st.x_rdata = x_val;
      next_st.x_valid = 1'b1;
      if (OP_LOAD && (int'(OP_DST) < NUM_WREG))
      begin
        if (OP_BYTE)
        begin
          next_st.w[OP_DST][7:0] = x_val[7:0];
        end
        else
        begin
          next_st.w[OP_DST] = x_val;
        end
      end
    end
    if (is_rd && OP_DUAL)
    begin
      next_st.y_rdata = y_word;
      next_st.y_valid = 1'b1;
      if (int'(OP_YPTR) < NUM_WREG)
      begin
        next_st.w[OP_YPTR] = y_next;
      end
    end
    if (take && (int'(OP_DST) < NUM_WREG))
    begin
      if (kind == KD_SIGNX)
      begin
        next_st.w[OP_DST] = {{8{src[7]}}, src[7:0]};
      end
      else if (kind == KD_ZEROX)
      begin
        next_st.w[OP_DST] = {8'h00, src[7:0]};
      end
    end
    // Trap after the access finishes, so state before it stays visible
    if (misaligned)
    begin
      next_st.trap = 1'b1;
      next_st.fsm = FS_TRAP;
      next_st.fault_ea = x_ea;
    end
    // Set beats clear so a fault in the clearing cycle is kept
    next_st.status = (st.status & ~st_clr) | st_set;
    // Software writes land last and win over the pipeline
    if (REG_WR)
    begin
      if (reg_idx < NUM_WREG)
      begin
        next_st.w[reg_idx] = REG_WDATA;
      end
      else if (REG_ADDR == OFS_MOD_CTRL)
      begin
        next_st.mod_ctrl = REG_WDATA[2:0];
      end
      else if (REG_ADDR == OFS_MOD_START)
      begin
        next_st.mod_start = REG_WDATA;
      end
      else if (REG_ADDR == OFS_MOD_END)
      begin
        next_st.mod_end = REG_WDATA;
      end
      else if (REG_ADDR == OFS_BREV_STEP)
      begin
        next_st.brev_step = REG_WDATA;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      st <= '0;
      st.fsm <= FS_RUN;
      st.w <= {NUM_WREG{WREG_RESET}};
      st.mod_ctrl <= MOD_CTRL_RESET;
      st.mod_start <= MOD_START_RESET;
      st.mod_end <= MOD_END_RESET;
      st.brev_step <= BREV_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign REG_RDATA = st.reg_rdata;
  assign X_RDATA = st.x_rdata;
  assign X_VALID = st.x_valid;
  assign Y_RDATA = st.y_rdata;
  assign Y_VALID = st.y_valid;
  assign OP_EA = st.ea_out;
  assign ADDR_TRAP = st.trap;

endmodule
